// ### rtl/acs_conv_if.sv
// Interface between the register side and the conversion sequencer.
`timescale 1ns/1ps
interface acs_conv_if;
  logic                       en;
  logic                       start;
  logic                       presc_reset;
  logic [acs_pkg::PS_W-1:0]   div_sel;
  logic [acs_pkg::ANA_W-1:0]  analog;
  logic                       busy;
  logic                       last_cycle;
  logic                       done;
  logic [acs_pkg::RES_W-1:0]  result;

  modport ctl  (output en, start, presc_reset, div_sel, analog,
                input  busy, last_cycle, done, result);
  modport conv (input  en, start, presc_reset, div_sel, analog,
                output busy, last_cycle, done, result);
endinterface : acs_conv_if

// ### rtl/acs_conv_seq.sv
// Prescaler and conversion cycle sequencer with result capture.
`timescale 1ns/1ps
module acs_conv_seq (
  input wire logic  i_ref_clk,
  input wire logic  i_rst,
  input wire logic  i_ce,
  acs_conv_if.conv  conv
);
  logic [acs_pkg::PRE_W-1:0] presc;
  logic [acs_pkg::PRE_W-1:0] presc_last;
  logic [acs_pkg::CNT_W-1:0] cnt;
  logic [acs_pkg::CNT_W-1:0] len;
  logic                      tick;
  logic                      pending;
  logic                      first;
  logic [acs_pkg::RES_W-1:0] sat_code;

  always_comb begin
    if (conv.div_sel == '0) begin
      presc_last = acs_pkg::PRE_MIN;
    end else begin
      presc_last = acs_pkg::PRE_W'((8'h01 << conv.div_sel) - 8'h01);
    end
  end
  assign tick = (presc == presc_last);
  assign conv.last_cycle = conv.busy && tick && (cnt == len - 1'b1);
  // Inputs above the reference clip to the top code.
  assign sat_code = conv.analog[acs_pkg::RES_W] ? acs_pkg::RES_MAX
                                                : conv.analog[acs_pkg::RES_W-1:0];

  // The prescaler is held while disabled and restarted by a hardware trigger.
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      presc <= '0;
    end else if (i_ce) begin
      if (!conv.en || conv.presc_reset || tick) begin
        presc <= '0;
      end else begin
        presc <= presc + 1'b1;
      end
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      first <= 1'b1;
    end else if (i_ce) begin
      if (!conv.en) begin
        first <= 1'b1;
      end else if (pending && tick && !conv.busy) begin
        first <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      pending <= 1'b0;
    end else if (i_ce) begin
      if (conv.start) begin
        pending <= 1'b1;
      end else if (!conv.en || (tick && !conv.busy)) begin
        pending <= 1'b0;
      end
    end
  end

  // A pending start begins on the next converter clock edge.
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      conv.busy <= 1'b0;
      cnt       <= '0;
      len       <= acs_pkg::LEN_NORMAL;
    end else if (i_ce) begin
      if (!conv.en) begin
        conv.busy <= 1'b0;
      end else if (tick && !conv.busy && pending) begin
        conv.busy <= 1'b1;
        cnt       <= '0;
        len       <= first ? acs_pkg::LEN_FIRST : acs_pkg::LEN_NORMAL;
      end else if (conv.last_cycle) begin
        conv.busy <= 1'b0;
      end else if (tick && conv.busy) begin
        cnt <= cnt + 1'b1;
      end
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      conv.done   <= 1'b0;
      conv.result <= acs_pkg::RES_RST;
    end else if (i_ce) begin
      conv.done <= conv.last_cycle && conv.en;
      if (conv.last_cycle && conv.en) begin
        conv.result <= sat_code;
      end
    end
  end

  property p_start_tick;
    @(posedge i_ref_clk) disable iff (i_rst)
      i_ce && conv.en && pending && tick && !conv.busy |=> conv.busy;
  endproperty
  a_start_tick: assert property (p_start_tick) else $error("pending start missed tick");

  property p_saturate;
    @(posedge i_ref_clk) disable iff (i_rst)
      i_ce && conv.en && conv.last_cycle && conv.analog[acs_pkg::RES_W]
      |=> conv.result == acs_pkg::RES_MAX;
  endproperty
  a_saturate: assert property (p_saturate) else $error("over-range not clipped");
endmodule : acs_conv_seq

// ### rtl/acs_pkg.sv
// Package with register map, field positions and conversion constants of the selection block.
package acs_pkg;
  localparam int unsigned CLK_HZ     = 100_000_000;
  localparam int unsigned CHAN_W     = 4;
  localparam int unsigned REF_W      = 2;
  localparam int unsigned RES_W      = 10;
  localparam int unsigned ANA_W      = 11;
  localparam int unsigned PS_W       = 3;
  localparam int unsigned PRE_W      = 7;
  localparam int unsigned CNT_W      = 5;
  localparam int unsigned ADDR_W     = 10;

  localparam logic [7:0] IDX_RESULT  = 8'h78;
  localparam logic [7:0] IDX_CTRL    = 8'h7a;
  localparam logic [7:0] IDX_CTRLB   = 8'h7b;
  localparam logic [7:0] IDX_SELECT  = 8'h7c;
  localparam logic [7:0] IDX_ACTIVE  = 8'h7d;
  localparam logic [ADDR_W-1:0] ADDR_RESULT = {IDX_RESULT, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_CTRL   = {IDX_CTRL, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_CTRLB  = {IDX_CTRLB, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_SELECT = {IDX_SELECT, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_ACTIVE = {IDX_ACTIVE, 2'h0};

  localparam int unsigned CTRL_EN    = 7;
  localparam int unsigned CTRL_START = 6;
  localparam int unsigned CTRL_AUTO  = 5;
  localparam int unsigned CTRL_FLAG  = 4;
  localparam int unsigned CTRL_IE    = 3;
  localparam int unsigned CTRL_PS    = 0;
  localparam int unsigned CTRLB_FREE = 0;
  localparam int unsigned SEL_REF    = 6;
  localparam int unsigned SEL_LADJ   = 5;
  localparam int unsigned SEL_CHAN   = 0;
  localparam int unsigned LADJ_PAD   = 6;

  localparam logic [7:0]       CTRL_RST   = 8'h00;
  localparam logic [7:0]       SEL_RST    = 8'h00;
  localparam logic [RES_W-1:0] RES_MAX    = 10'h3ff;
  localparam logic [RES_W-1:0] RES_RST    = 10'h000;
  localparam logic [CNT_W-1:0] LEN_NORMAL = 5'h0d;
  localparam logic [CNT_W-1:0] LEN_FIRST  = 5'h19;
  localparam logic [PRE_W-1:0] PRE_MIN    = 7'h01;
  localparam logic [1:0]       HTRANS_NONSEQ = 2'h2;
endpackage : acs_pkg

// ### rtl/acs_select_ctrl.sv
// Top of the converter selection control with its register slave and sleep start logic.
//
// Local design decisions: register access over AHB-Lite and the register addresses.
`timescale 1ns/1ps
module acs_select_ctrl (
  input  wire logic                       i_ref_clk,
  input  wire logic                       i_rst,
  input  wire logic                       i_ce,
  input  wire logic                       hsel,
  input  wire logic [31:0]                haddr,
  input  wire logic [1:0]                 htrans,
  input  wire logic                       hwrite,
  input  wire logic [2:0]                 hsize,
  input  wire logic                       hready,
  input  wire logic [31:0]                hwdata,
  output logic      [31:0]                hrdata,
  output logic                            hreadyout,
  output logic                            hresp,
  input  wire logic                       i_trigger,
  input  wire logic [acs_pkg::ANA_W-1:0]  i_analog_code,
  input  wire logic                       i_sleep_quiet,
  input  wire logic                       i_cpu_halted,
  input  wire logic                       i_irq_ack,
  output logic      [acs_pkg::CHAN_W-1:0] o_channel_select,
  output logic      [acs_pkg::REF_W-1:0]  o_reference_select,
  output logic                            o_converter_enable,
  output logic                            o_done_req,
  output logic                            o_wake
);
  acs_conv_if conv_if ();

  logic                       wr_q;
  logic [acs_pkg::ADDR_W-1:0] addr_q;
  logic                       wr_ctrl;
  logic                       wr_ctrlb;
  logic                       wr_sel;
  logic [31:0]                next_rdata;
  logic                       converter_enable;
  logic                       conversion_start_bit;
  logic                       auto_trigger_enable;
  logic                       conversion_done_flag;
  logic                       done_irq_enable;
  logic [acs_pkg::PS_W-1:0]   prescale;
  logic                       free_run;
  logic [7:0]                 input_select_register;
  logic [acs_pkg::CHAN_W-1:0] channel_select;
  logic [acs_pkg::REF_W-1:0]  reference_select;
  logic                       trig_s1;
  logic                       trig_s2;
  logic                       trig_q;
  logic [acs_pkg::ANA_W-1:0]  ana_s1;
  logic [acs_pkg::ANA_W-1:0]  ana_s2;
  logic                       sleep_q;
  logic                       sleep_conv;
  logic                       sw_start;
  logic                       ext_start;
  logic                       fr_start;
  logic                       sleep_start;
  logic                       start_evt;

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign wr_ctrl   = wr_q && (addr_q == acs_pkg::ADDR_CTRL);
  assign wr_ctrlb  = wr_q && (addr_q == acs_pkg::ADDR_CTRLB);
  assign wr_sel    = wr_q && (addr_q == acs_pkg::ADDR_SELECT);

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      wr_q   <= 1'b0;
      addr_q <= '0;
    end else if (i_ce) begin
      wr_q   <= hsel && hready && (htrans == acs_pkg::HTRANS_NONSEQ) && hwrite;
      addr_q <= haddr[acs_pkg::ADDR_W-1:0];
    end
  end

  // Read data is fetched in the address phase so the slave never inserts waits.
  always_comb begin
    next_rdata = '0;
    if (haddr[31:acs_pkg::ADDR_W] != '0) begin
      next_rdata = '0;
    end else if (haddr[acs_pkg::ADDR_W-1:0] == acs_pkg::ADDR_CTRL) begin
      next_rdata[7:0] = {converter_enable, conversion_start_bit, auto_trigger_enable,
                         conversion_done_flag, done_irq_enable, prescale};
    end else if (haddr[acs_pkg::ADDR_W-1:0] == acs_pkg::ADDR_CTRLB) begin
      next_rdata[acs_pkg::CTRLB_FREE] = free_run;
    end else if (haddr[acs_pkg::ADDR_W-1:0] == acs_pkg::ADDR_SELECT) begin
      next_rdata[7:0] = input_select_register;
    end else if (haddr[acs_pkg::ADDR_W-1:0] == acs_pkg::ADDR_ACTIVE) begin
      next_rdata[7:0] = {reference_select, 2'h0, channel_select};
    end else if (haddr[acs_pkg::ADDR_W-1:0] == acs_pkg::ADDR_RESULT) begin
      if (input_select_register[acs_pkg::SEL_LADJ]) begin
        next_rdata[15:0] = {conv_if.result, acs_pkg::LADJ_PAD'(0)};
      end else begin
        next_rdata[15:0] = {acs_pkg::LADJ_PAD'(0), conv_if.result};
      end
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      hrdata <= '0;
    end else if (i_ce && hsel && hready && (htrans == acs_pkg::HTRANS_NONSEQ) && !hwrite) begin
      hrdata <= next_rdata;
    end
  end

  // The trigger and the analog code arrive from pins and are synchronised first.
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      trig_s1 <= 1'b0;
      trig_s2 <= 1'b0;
      trig_q  <= 1'b0;
      ana_s1  <= '0;
      ana_s2  <= '0;
      sleep_q <= 1'b0;
    end else if (i_ce) begin
      trig_s1 <= i_trigger;
      trig_s2 <= trig_s1;
      trig_q  <= trig_s2;
      ana_s1  <= i_analog_code;
      ana_s2  <= ana_s1;
      sleep_q <= i_sleep_quiet && i_cpu_halted;
    end
  end

  assign sw_start    = wr_ctrl && hwdata[acs_pkg::CTRL_START] && hwdata[acs_pkg::CTRL_EN]
                       && !conversion_start_bit;
  assign ext_start   = converter_enable && auto_trigger_enable && !free_run
                       && trig_s2 && !trig_q && !conversion_start_bit;
  assign fr_start    = converter_enable && auto_trigger_enable && free_run
                       && conv_if.done;
  assign sleep_start = converter_enable && !conversion_start_bit && !auto_trigger_enable
                       && done_irq_enable && i_sleep_quiet && i_cpu_halted && !sleep_q;
  assign start_evt   = sw_start || ext_start || fr_start || sleep_start;

  assign conv_if.en          = converter_enable;
  assign conv_if.start       = start_evt;
  assign conv_if.presc_reset = ext_start;
  assign conv_if.div_sel     = prescale;
  assign conv_if.analog      = ana_s2;

  acs_conv_seq u_seq (
    .i_ref_clk (i_ref_clk),
    .i_rst     (i_rst),
    .i_ce      (i_ce),
    .conv      (conv_if)
  );

  // Enable is changed by software only; no sleep mode touches it.
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      converter_enable    <= acs_pkg::CTRL_RST[acs_pkg::CTRL_EN];
      auto_trigger_enable <= acs_pkg::CTRL_RST[acs_pkg::CTRL_AUTO];
      done_irq_enable     <= acs_pkg::CTRL_RST[acs_pkg::CTRL_IE];
      prescale            <= acs_pkg::CTRL_RST[acs_pkg::CTRL_PS +: acs_pkg::PS_W];
      free_run            <= 1'b0;
    end else if (i_ce) begin
      if (wr_ctrl) begin
        converter_enable    <= hwdata[acs_pkg::CTRL_EN];
        auto_trigger_enable <= hwdata[acs_pkg::CTRL_AUTO];
        done_irq_enable     <= hwdata[acs_pkg::CTRL_IE];
        prescale            <= hwdata[acs_pkg::CTRL_PS +: acs_pkg::PS_W];
      end
      if (wr_ctrlb) begin
        free_run <= hwdata[acs_pkg::CTRLB_FREE];
      end
    end
  end

  // In free running the restart comes with completion, so the bit stays high.
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      conversion_start_bit <= 1'b0;
    end else if (i_ce) begin
      if (start_evt) begin
        conversion_start_bit <= 1'b1;
      end else if (!converter_enable || conv_if.done) begin
        conversion_start_bit <= 1'b0;
      end
    end
  end

  // A completion in the clearing cycle wins over the clear.
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      conversion_done_flag <= 1'b0;
    end else if (i_ce) begin
      if (conv_if.done) begin
        conversion_done_flag <= 1'b1;
      end else if ((wr_ctrl && hwdata[acs_pkg::CTRL_FLAG]) || i_irq_ack) begin
        conversion_done_flag <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      input_select_register <= acs_pkg::SEL_RST;
    end else if (i_ce && wr_sel) begin
      input_select_register <= hwdata[7:0];
    end
  end

  // Tracking covers the wait for the first converter edge after a start as well.
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      channel_select   <= acs_pkg::SEL_RST[acs_pkg::SEL_CHAN +: acs_pkg::CHAN_W];
      reference_select <= acs_pkg::SEL_RST[acs_pkg::SEL_REF +: acs_pkg::REF_W];
    end else if (i_ce && (!conv_if.busy || conv_if.last_cycle)) begin
      channel_select   <= input_select_register[acs_pkg::SEL_CHAN +: acs_pkg::CHAN_W];
      reference_select <= input_select_register[acs_pkg::SEL_REF +: acs_pkg::REF_W];
    end
  end

  // The wake pulse is single; staying awake afterwards is the CPU's default.
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      sleep_conv <= 1'b0;
      o_wake     <= 1'b0;
    end else if (i_ce) begin
      o_wake <= conv_if.done && sleep_conv && done_irq_enable;
      if (sleep_start) begin
        sleep_conv <= 1'b1;
      end else if (conv_if.done || !converter_enable) begin
        sleep_conv <= 1'b0;
      end
    end
  end

  assign o_channel_select   = channel_select;
  assign o_reference_select = reference_select;
  assign o_converter_enable = converter_enable;
  assign o_done_req         = conversion_done_flag && done_irq_enable;

  property p_track;
    @(posedge i_ref_clk) disable iff (i_rst)
      i_ce && !conv_if.busy |=> channel_select == $past(input_select_register[3:0]);
  endproperty
  a_track: assert property (p_track) else $error("idle selection not tracking");

  property p_freeze;
    @(posedge i_ref_clk) disable iff (i_rst)
      conv_if.busy && !conv_if.last_cycle |=> $stable(channel_select) && $stable(reference_select);
  endproperty
  a_freeze: assert property (p_freeze) else $error("selection moved during conversion");

  property p_resume;
    @(posedge i_ref_clk) disable iff (i_rst)
      i_ce && conv_if.last_cycle |=> reference_select == $past(input_select_register[7:6]);
  endproperty
  a_resume: assert property (p_resume) else $error("no update in last cycle");

  property p_bit_busy;
    @(posedge i_ref_clk) disable iff (i_rst)
      conv_if.busy |-> conversion_start_bit;
  endproperty
  a_bit_busy: assert property (p_bit_busy) else $error("start bit low while busy");

  property p_single_clear;
    @(posedge i_ref_clk) disable iff (i_rst)
      i_ce && conv_if.done && !fr_start && !start_evt |=> !conversion_start_bit;
  endproperty
  a_single_clear: assert property (p_single_clear) else $error("start bit not cleared");

  property p_done_flag;
    @(posedge i_ref_clk) disable iff (i_rst)
      i_ce && conv_if.done |=> conversion_done_flag && $past(conv_if.last_cycle, 2);
  endproperty
  a_done_flag: assert property (p_done_flag) else $error("done flag not set");

  sequence s_fr_done;
    i_ce && fr_start;
  endsequence
  sequence s_fr_busy;
    conversion_start_bit ##[1:300] conv_if.busy;
  endsequence
  property p_free_run;
    @(posedge i_ref_clk) disable iff (i_rst || !i_ce || !converter_enable)
      s_fr_done |=> s_fr_busy;
  endproperty
  a_free_run: assert property (p_free_run) else $error("free run did not restart");

  property p_sleep;
    @(posedge i_ref_clk) disable iff (i_rst)
      i_ce && sleep_start |=> conversion_start_bit && sleep_conv;
  endproperty
  a_sleep: assert property (p_sleep) else $error("sleep start missed");

  property p_req;
    @(posedge i_ref_clk) disable iff (i_rst)
      i_ce && conv_if.done && done_irq_enable |=> o_done_req;
  endproperty
  a_req: assert property (p_req) else $error("completion request missing");
endmodule : acs_select_ctrl

// ### testbench/acs_select_ctrl_bench.sv
// Self-checking bench for the converter selection control block.
`timescale 1ns/1ps
module acs_select_ctrl_bench;
  logic        clk;
  logic        rst;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic [10:0] analog;
  logic        quiet;
  logic        halted;
  logic        irq_ack;
  logic [3:0]  chan;
  logic [1:0]  refsel;
  logic        done_req;
  logic        wake;
  logic        trig;
  logic        enable;
  logic        rd_phase;
  logic [31:0] expq[$];
  int          bad_count;
  int          compares;
  int          cycles;
  logic [7:0]  sel1;
  logic [7:0]  sel2;
  logic [7:0]  sel3;
  logic [7:0]  sel4;
  logic [7:0]  sel5;

  acs_select_ctrl dut (
    .i_ref_clk(clk), .i_rst(rst), .i_ce(1'b1), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout),
    .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .i_trigger(trig), .i_analog_code(analog), .i_sleep_quiet(quiet),
    .i_cpu_halted(halted), .i_irq_ack(irq_ack), .o_channel_select(chan),
    .o_reference_select(refsel), .o_converter_enable(enable), .o_done_req(done_req),
    .o_wake(wake)
  );

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // The bus answers with zero wait, but the master still waits on hready for safety.
  task automatic bus(input logic wr, input logic [9:0] addr, input logic [31:0] data);
    @(posedge clk);
    hsel   <= 1'b1;
    haddr  <= {22'h0, addr};
    htrans <= acs_pkg::HTRANS_NONSEQ;
    hwrite <= wr;
    if (!wr) expq.push_back(data);
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wr ? data : 32'h0;
    do @(posedge clk); while (hreadyout !== 1'b1);
  endtask : bus

  task automatic wait_done;
    do begin
      @(posedge clk);
      #1;
    end while (done_req !== 1'b1);
  endtask : wait_done

  task automatic ack;
    @(posedge clk);
    irq_ack <= 1'b1;
    @(posedge clk);
    irq_ack <= 1'b0;
    @(posedge clk);
  endtask : ack

  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : stop_test

  // Read data is compared in the data phase, against the oldest note.
  always @(posedge clk) begin
    if (rd_phase) begin
      if (expq.size() == 0) begin
        bad_count++;
        $display("unexpected at %0t: read with no expectation", $time);
      end else begin
        check(hrdata, expq.pop_front());
      end
    end
    rd_phase <= hsel && hreadyout && htrans == acs_pkg::HTRANS_NONSEQ && !hwrite;
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      bad_count++;
      stop_test();
    end
  end

  initial begin
    void'($urandom(32'hdad26888));
    {hsel, hwrite, quiet, halted, irq_ack, trig} = 6'h00;
    haddr  = 32'h0;
    htrans = 2'h0;
    hsize  = 3'h2;
    hwdata = 32'h0;
    analog = 11'h000;
    rst    = 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    bus(1'b0, acs_pkg::ADDR_CTRL, 32'h0);
    bus(1'b0, acs_pkg::ADDR_SELECT, 32'h0);
    bus(1'b0, acs_pkg::ADDR_ACTIVE, 32'h0);
    bus(1'b0, acs_pkg::ADDR_RESULT, 32'h0);
    bus(1'b0, 10'h3fc, 32'h0);
    $display("test reset values done");
    sel1 = {2'($urandom()), 2'h0, 4'($urandom())};
    bus(1'b1, acs_pkg::ADDR_SELECT, {24'h0, sel1});
    bus(1'b0, acs_pkg::ADDR_ACTIVE, {24'h0, sel1});
    #1;
    check({28'h0, chan}, {28'h0, sel1[3:0]});
    check({30'h0, refsel}, {30'h0, sel1[7:6]});
    $display("test idle tracking done");
    @(posedge clk);
    analog <= {1'b0, 10'($urandom())};
    bus(1'b1, acs_pkg::ADDR_CTRL, 32'hca);
    repeat (10) @(posedge clk);
    sel2 = sel1 ^ 8'hc5;
    bus(1'b1, acs_pkg::ADDR_SELECT, {24'h0, sel2});
    bus(1'b0, acs_pkg::ADDR_CTRL, 32'hca);
    #1;
    check({28'h0, chan}, {28'h0, sel1[3:0]});
    check({30'h0, refsel}, {30'h0, sel1[7:6]});
    wait_done();
    check({28'h0, chan}, {28'h0, sel2[3:0]});
    check({30'h0, refsel}, {30'h0, sel2[7:6]});
    bus(1'b0, acs_pkg::ADDR_RESULT, {22'h0, analog[9:0]});
    bus(1'b0, acs_pkg::ADDR_CTRL, 32'h9a);
    bus(1'b1, acs_pkg::ADDR_CTRL, 32'h9a);
    analog <= {1'b1, 10'($urandom())};
    #1;
    check({31'h0, done_req}, 32'h0);
    bus(1'b1, acs_pkg::ADDR_CTRL, 32'hca);
    wait_done();
    bus(1'b0, acs_pkg::ADDR_RESULT, {22'h0, acs_pkg::RES_MAX});
    ack();
    #1;
    check({31'h0, done_req}, 32'h0);
    $display("test single conversions done");
    @(posedge clk);
    quiet  <= 1'b1;
    halted <= 1'b1;
    do begin
      @(posedge clk);
      #1;
    end while (wake !== 1'b1);
    check({31'h0, done_req}, 32'h1);
    check({31'h0, enable}, 32'h1);
    @(posedge clk);
    #1;
    check({31'h0, wake}, 32'h0);
    @(posedge clk);
    quiet  <= 1'b0;
    halted <= 1'b0;
    ack();
    $display("test sleep start done");
    bus(1'b1, acs_pkg::ADDR_CTRLB, 32'h1);
    bus(1'b1, acs_pkg::ADDR_CTRL, 32'hea);
    wait_done();
    bus(1'b0, acs_pkg::ADDR_CTRL, 32'hfa);
    sel3 = sel2 ^ 8'h4a;
    bus(1'b1, acs_pkg::ADDR_SELECT, {24'h0, sel3});
    #1;
    check({28'h0, chan}, {28'h0, sel2[3:0]});
    ack();
    wait_done();
    check({28'h0, chan}, {28'h0, sel3[3:0]});
    check({30'h0, refsel}, {30'h0, sel3[7:6]});
    bus(1'b1, acs_pkg::ADDR_CTRL, 32'h0);
    #1;
    check({31'h0, enable}, 32'h0);
    $display("test free running done");
    sel4 = sel3 ^ 8'h03;
    bus(1'b1, acs_pkg::ADDR_SELECT, {24'h0, sel4});
    bus(1'b1, acs_pkg::ADDR_CTRLB, 32'h0);
    bus(1'b1, acs_pkg::ADDR_CTRL, 32'hba);
    trig <= 1'b1;
    repeat (8) @(posedge clk);
    sel5 = sel4 ^ 8'hcc;
    bus(1'b1, acs_pkg::ADDR_SELECT, {24'h0, sel5});
    #1;
    check({28'h0, chan}, {28'h0, sel4[3:0]});
    check({30'h0, refsel}, {30'h0, sel4[7:6]});
    wait_done();
    check({28'h0, chan}, {28'h0, sel5[3:0]});
    check({30'h0, refsel}, {30'h0, sel5[7:6]});
    bus(1'b0, acs_pkg::ADDR_CTRL, 32'hba);
    trig <= 1'b0;
    ack();
    bus(1'b1, acs_pkg::ADDR_CTRL, 32'h0);
    $display("test auto trigger done");
    stop_test();
  end
endmodule : acs_select_ctrl_bench
